// ==== stl_pkg.sv ====
package stl_pkg;
   localparam int POS_W = 32;
   localparam logic [7:0] REG_FIRST_MIN = 8'h0A;
   localparam logic [7:0] REG_FIRST_MAX = 8'hC6;
   localparam logic [7:0] REG_DISABLE = 8'h00;
   localparam int STATUS_LIMIT_BIT = 1;
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [31:0] TARGET_RST = 32'h00000000;

   typedef struct packed {
      logic [POS_W-1:0] lower;
      logic [POS_W-1:0] upper;
   } stl_bounds_s;

   typedef enum logic [1:0] {
      STL_IDLE = 2'b00,
      STL_MOVE = 2'b01,
      STL_HELD = 2'b10
   } stl_state_e;
endpackage

// ==== stl_soft_travel_limiter.sv ====
`timescale 1ns/10ps
module stl_soft_travel_limiter (
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Configuration and register file view.
   input wire logic [7:0] i_start_reg,
   input wire stl_pkg::stl_bounds_s i_bounds,
   // Trajectory generator.
   input wire logic i_move_start,
   input wire logic [stl_pkg::POS_W-1:0] i_move_goal,
   input wire logic i_profile_valid,
   input wire logic [stl_pkg::POS_W-1:0] i_profile_pos,
   // Direct target write.
   input wire logic i_direct_wr,
   input wire logic [stl_pkg::POS_W-1:0] i_direct_val,
   // Results.
   output logic [stl_pkg::POS_W-1:0] o_target,
   output logic [15:0] o_second_internal_status_word,
   output logic o_limit_active,
   output logic o_profile_ready
);
   localparam int W = stl_pkg::POS_W;

   stl_pkg::stl_state_e state_r, state_nxt;
   logic [W-1:0] target_r, target_nxt;
   logic [15:0] status_r, status_nxt;
   logic limit_r, limit_nxt;
   logic ready_r, ready_nxt;
   logic enabled;
   logic signed [W-1:0] lo, hi, tgt, cand, goal;
   logic neg_step, pos_step, block, goal_beyond;

   always_comb begin
      // Bound values are sampled live each cycle, not latched at the command.
      lo = $signed(i_bounds.lower);
      hi = $signed(i_bounds.upper);
      tgt = $signed(target_r);
      cand = $signed(i_profile_pos);
      goal = $signed(i_move_goal);
      // Out-of-range start registers are treated as disabled as well.
      enabled = (i_start_reg != stl_pkg::REG_DISABLE) &&
         (i_start_reg >= stl_pkg::REG_FIRST_MIN) &&
         (i_start_reg <= stl_pkg::REG_FIRST_MAX);
      neg_step = cand < tgt;
      pos_step = cand > tgt;
      // Signed compare keeps the range linear, so a wrap looks like a huge jump.
      block = enabled && ((neg_step && cand <= lo) || (pos_step && cand >= hi));
      goal_beyond = enabled && ((goal < tgt && goal <= lo) || (goal > tgt && goal >= hi));
      // A dead zone gives lo>=hi, so any move from inside it is blocked.
      ready_nxt = 1'b1;
      state_nxt = state_r;
      target_nxt = target_r;
      status_nxt = status_r;
      limit_nxt = 1'b0;
      if (i_direct_wr) begin
         target_nxt = i_direct_val;
         state_nxt = stl_pkg::STL_IDLE;
      end else begin
         case (state_r)
            stl_pkg::STL_IDLE: begin
               if (i_move_start) begin
                  state_nxt = stl_pkg::STL_MOVE;
                  if (goal_beyond) begin
                     status_nxt[stl_pkg::STATUS_LIMIT_BIT] = 1'b1;
                  end
               end
            end
            stl_pkg::STL_MOVE, stl_pkg::STL_HELD: begin
               if (i_move_start) begin
                  if (goal_beyond) begin
                     status_nxt[stl_pkg::STATUS_LIMIT_BIT] = 1'b1;
                  end
               end
               if (i_profile_valid) begin
                  if (block) begin
                     // Ramp ends on the last in-range step; profile output is dropped.
                     state_nxt = stl_pkg::STL_HELD;
                     limit_nxt = 1'b1;
                     status_nxt[stl_pkg::STATUS_LIMIT_BIT] = 1'b1;
                  end else begin
                     // Motion back toward the range is passed unless the step reaches or crosses the opposite bound.
                     target_nxt = i_profile_pos;
                     state_nxt = stl_pkg::STL_MOVE;
                  end
               end else if (state_r == stl_pkg::STL_HELD) begin
                  limit_nxt = 1'b1;
               end
            end
            default: begin
               state_nxt = stl_pkg::STL_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_r <= stl_pkg::STL_IDLE;
         target_r <= stl_pkg::TARGET_RST;
         status_r <= stl_pkg::STATUS_RST;
         limit_r <= 1'b0;
         ready_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         target_r <= target_nxt;
         status_r <= status_nxt;
         limit_r <= limit_nxt;
         ready_r <= ready_nxt;
      end
   end

   assign o_target = target_r;
   assign o_second_internal_status_word = status_r;
   assign o_limit_active = limit_r;
   assign o_profile_ready = ready_r;

   a_disabled_passes: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_start_reg == stl_pkg::REG_DISABLE && !i_direct_wr && i_profile_valid
       && state_r != stl_pkg::STL_IDLE) |=> (o_target == $past(i_profile_pos)))
      else $error("Disabled limiter altered a move target.");
   a_direct_bypass: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      i_direct_wr |=> (o_target == $past(i_direct_val)))
      else $error("Direct write did not reach the target.");
   a_block_holds: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (!i_direct_wr && block && i_profile_valid && state_r != stl_pkg::STL_IDLE)
      |=> ($stable(o_target) && o_limit_active))
      else $error("Blocked step moved the target.");
   a_limit_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_limit_active |-> o_second_internal_status_word[stl_pkg::STATUS_LIMIT_BIT])
      else $error("Limiting without status flag.");
   a_cmd_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (!i_direct_wr && i_move_start && goal_beyond)
      |=> o_second_internal_status_word[stl_pkg::STATUS_LIMIT_BIT])
      else $error("Command beyond bound not flagged.");
   a_upper_kept: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (enabled && !i_direct_wr && i_profile_valid && pos_step
       && state_r != stl_pkg::STL_IDLE) |=> ($signed(o_target) < $past(hi)
       || o_target == $past(target_r)))
      else $error("Target crossed upper bound.");
   a_lower_kept: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (enabled && !i_direct_wr && i_profile_valid && neg_step
       && state_r != stl_pkg::STL_IDLE) |=> ($signed(o_target) > $past(lo)
       || o_target == $past(target_r)))
      else $error("Target crossed lower bound.");
   a_return_ok: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (enabled && !i_direct_wr && i_profile_valid && state_r != stl_pkg::STL_IDLE
       && tgt >= hi && neg_step && cand > lo) |=> (o_target == $past(i_profile_pos)))
      else $error("Return toward range was refused.");
endmodule

// ==== stl_traj_model.sv ====
`timescale 1ns/10ps
// The profile keeps stepping while the limiter holds, so held steps pile up past the bound.
module stl_traj_model (
   // Clock and command.
   input wire logic i_sys_clk,
   input wire logic i_go,
   input wire logic i_stall,
   input wire logic [31:0] i_goal,
   input wire logic [31:0] i_from,
   // To the limiter.
   output logic o_move_start = 1'b0,
   output logic o_profile_valid = 1'b0,
   output logic [31:0] o_profile_pos = 32'h00000000
);
   int goal = 0;
   always @(posedge i_sys_clk) begin
      o_move_start <= i_go;
      o_profile_valid <= !i_go && !i_stall;
      if (i_go) begin
         goal = $signed(i_goal);
         o_profile_pos <= i_from;
      end else if (!i_stall && goal != $signed(o_profile_pos)) begin
         o_profile_pos <= o_profile_pos + (goal > $signed(o_profile_pos) ? 32'h1 : 32'hFFFFFFFF);
      end
   end
endmodule

// ==== stl_soft_travel_limiter_tb.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module stl_soft_travel_limiter_tb;
   logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, stall = 1'b0, dwr = 1'b0;
   logic lim, rdy, mst, pv, ms = 1'b0, rdm = 1'b0, blk = 1'b0, mv = 1'b0, en, hd = 1'b0;
   logic [7:0] sreg = 8'h00;
   logic [7:0] regs [6] = '{8'h00, 8'h09, 8'h0A, 8'hC6, 8'hC7, 8'h64};
   logic [15:0] stw;
   logic [31:0] goal = 32'h0, dval = 32'h0, frm = 32'h0, rs = 32'h9952, r, tgt, ppos;
   logic signed [31:0] mt = 32'sh0, lo, hi, pp;
   stl_pkg::stl_bounds_s bnd = '0;
   int num_errors = 0, n_tests = 0, cyc = 0;
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task stop_test();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always #4 clk = ~clk;
   stl_traj_model traj (.i_sys_clk(clk), .i_go(go), .i_stall(stall), .i_goal(goal),
      .i_from(frm), .o_move_start(mst), .o_profile_valid(pv), .o_profile_pos(ppos));
   stl_soft_travel_limiter dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_start_reg(sreg),
      .i_bounds(bnd), .i_move_start(mst), .i_move_goal(goal), .i_profile_valid(pv),
      .i_profile_pos(ppos), .i_direct_wr(dwr), .i_direct_val(dval), .o_target(tgt),
      .o_second_internal_status_word(stw), .o_limit_active(lim), .o_profile_ready(rdy));
   always @(posedge clk) begin
      if (cyc > 0) begin
         `CHK("target", mt, tgt)
         `CHK("status", {14'h0000, ms, 1'b0}, stw)
         `CHK("ready", rdm, rdy)
         `CHK("limit", hd, lim)
      end
      en = sreg >= stl_pkg::REG_FIRST_MIN && sreg <= stl_pkg::REG_FIRST_MAX;
      lo = bnd.lower;
      hi = bnd.upper;
      pp = ppos;
      blk = 1'b0;
      rdm = rst_n;
      if (!rst_n) begin
         mt = 32'sh0;
         ms = 1'b0;
         mv = 1'b0;
         hd = 1'b0;
      end else if (dwr) begin
         mt = dval;
         mv = 1'b0;
         hd = 1'b0;
      end else if (mst) begin
         mv = 1'b1;
         if (en && (($signed(goal) > mt && $signed(goal) >= hi)
            || ($signed(goal) < mt && $signed(goal) <= lo))) ms = 1'b1;
      end else if (pv && mv) begin
         blk = en && ((pp > mt && pp >= hi) || (pp < mt && pp <= lo));
         hd = blk;
         if (blk) ms = 1'b1;
         else mt = pp;
      end
      r = xs();
      cyc++;
      rst_n <= cyc >= 4 && cyc != 3000;
      frm <= mt;
      go <= !go && r[3:0] == 4'h0;
      if (!go && r[3:0] == 4'h0) goal <= r[12] ? 32'h7FFFFFF0 : {{25{r[10]}}, r[10:4]};
      // Direct writes avoid move cycles so both never land on one edge.
      dwr <= r[9:4] == 6'h01 && !go;
      dval <= {{25{r[22]}}, r[22:16]};
      stall <= r[23];
      if (cyc % 300 == 0) sreg <= regs[r[26:24] % 6];
      if (cyc % 150 == 0) bnd <= {{25{r[30]}}, r[30:24], {25{r[17]}}, r[17:11]};
   end
   initial begin
      #800000;
      num_errors++;
      stop_test();
   end
   initial begin
      repeat (6000) @(posedge clk);
      stop_test();
   end
endmodule
